// ---- verilog/sig_io_pkg.sv ----
// Constants and carrier types for the signal board status and I/O block.
// What this block does
// - At power-up all seven status LEDs blink together exactly once.
// - Then each LED blinks once in turn, axis 1 first, power last.
// - After the sequence axis LEDs stay off between steps and the power LED stays on.
// - After the sequence the USB LED follows the cable-present signal.
// - Axis LEDs pulse with commanded steps, brighter at higher speed.
// - Software picks normally closed or normally open for each input.
// - Inputs with the polarity bit clear report open for a high line and closed for a low line.
// - All general-purpose outputs are low from power-on until written.
// - Eight independently driven general-purpose output lines exist.
// - Outputs 1 and 2 also appear on the motor connector unchanged.
// - Inputs 1 to 8 also appear on the motor connector unchanged.
// - Step and direction for five axes plus a global enable go out.
package sig_io_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] OUT_OFS    = 12'h000;
  localparam logic [11:0] POL_OFS    = 12'h004;
  localparam logic [11:0] IN_OFS     = 12'h008;
  localparam logic [11:0] MOTION_OFS = 12'h00c;
  localparam logic [11:0] STAT_OFS   = 12'h010;

  localparam logic [7:0]  OUT_RST    = 8'h00;
  localparam logic [7:0]  POL_RST    = 8'h00;
  localparam logic [5:0]  MOTION_RST = 6'h00;
  localparam int          MOT_ENA_BIT = 5;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;
  localparam int BLINK_MS    = 200;
  localparam int BLINK_CYC   = BLINK_MS * (CLK_HZ / 1000);
  localparam int PULSE_US    = 5;
  localparam int PULSE_CYC   = PULSE_US * (CLK_HZ / 1_000_000);
  localparam int LED_CNT     = 7;
  localparam int AXES        = 5;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_ALL_ON  = 4'b0001,
    ST_ALL_OFF = 4'b0010,
    ST_WALK    = 4'b0100,
    ST_RUN     = 4'b1000
  } led_state_t;

  typedef struct packed {
    logic [4:0] step;
    logic [4:0] dir;
    logic       enable;
  } drive_t;

endpackage : sig_io_pkg

// ---- verilog/sig_io_leds.sv ----
// Status LEDs, isolated inputs, outputs and drive signals of the board.
`timescale 1ns/1ns
module sig_io_leds #(
  parameter int BLINK_CYC = sig_io_pkg::BLINK_CYC,
  parameter int PULSE_CYC = sig_io_pkg::PULSE_CYC
) (
  // Clock and reset.
  input  wire logic               ref_clk_i,
  input  wire logic               reset_i,
  input  wire logic               clk_en_i,
  // APB slave.
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [11:0]        paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // Pins.
  input  wire logic [7:0]         in_pins_i,
  input  wire logic               usb_cable_i,
  output logic      [7:0]         out_pins_o,
  output logic      [1:0]         motor_out_o,
  output logic      [7:0]         motor_in_o,
  output sig_io_pkg::drive_t      drive_o,
  output logic      [6:0]         leds_o
);

  // Counts that the sequencer and pulse counters cannot serve.
  if (BLINK_CYC < 2) begin : g_bad_blink
    $error("sig_io_leds: BLINK_CYC below 2");
  end
  if (PULSE_CYC < 2) begin : g_bad_pulse
    $error("sig_io_leds: PULSE_CYC below 2");
  end
  // The pulse counter is sixteen bits wide.
  if (PULSE_CYC > 65535) begin : g_big_pulse
    $error("sig_io_leds: PULSE_CYC too large");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (clk_en_i) begin
      sync1_reg <= {usb_cable_i, in_pins_i};
      sync2_reg <= sync1_reg;
    end
  end

  wire logic [7:0] in_sync  = sync2_reg[7:0];
  wire logic       usb_sync = sync2_reg[8];

  // ----------------------------------------------------------------------
  // Registers and APB
  // ----------------------------------------------------------------------
  logic [7:0] out_reg;
  logic [7:0] pol_reg;
  logic [5:0] motion_reg;
  logic [4:0] step_reg;
  logic [4:0] dir_reg;

  wire logic wr_en = psel_i & penable_i & pwrite_i & clk_en_i;
  wire logic hit_out = (paddr_i == sig_io_pkg::OUT_OFS);
  wire logic hit_pol = (paddr_i == sig_io_pkg::POL_OFS);
  wire logic hit_in  = (paddr_i == sig_io_pkg::IN_OFS);
  wire logic hit_mot = (paddr_i == sig_io_pkg::MOTION_OFS);
  wire logic hit_st  = (paddr_i == sig_io_pkg::STAT_OFS);
  wire logic hit_any = hit_out | hit_pol | hit_in | hit_mot | hit_st;

  // Normally closed lines read inverted so that a tripped switch shows open.
  wire logic [7:0] in_status = in_sync ^ pol_reg;

  logic [31:0] rd_mux;
  logic [3:0]  state_reg;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_out) rd_mux = {24'h00_0000, out_reg};
    if (hit_pol) rd_mux = {24'h00_0000, pol_reg};
    if (hit_in)  rd_mux = {24'h00_0000, in_status};
    if (hit_mot) rd_mux = {26'h000_0000, motion_reg};
    if (hit_st)  rd_mux = {27'h000_0000, usb_sync, state_reg};
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit_any;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (clk_en_i && psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_reg    <= sig_io_pkg::OUT_RST;
      pol_reg    <= sig_io_pkg::POL_RST;
      motion_reg <= sig_io_pkg::MOTION_RST;
    end else if (wr_en) begin
      if (hit_out) out_reg <= pwdata_i[7:0];
      if (hit_pol) pol_reg <= pwdata_i[7:0];
      if (hit_mot) motion_reg <= pwdata_i[5:0];
    end
  end

  // Write of the motion register bits 0..4 as a 1 issues one step on each axis whose pulse counter is zero.
  wire logic [4:0] step_req = (wr_en & hit_mot) ? pwdata_i[4:0] : 5'h00;
  wire logic [4:0] dir_wr   = pwdata_i[12:8];

  // ----------------------------------------------------------------------
  // Step pulse generators
  // ----------------------------------------------------------------------
  logic [4:0][15:0] pcnt_reg;
  genvar g;
  for (g = 0; g < sig_io_pkg::AXES; g++) begin : g_axis
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
        pcnt_reg[g] <= 16'h0000;
        step_reg[g] <= 1'b0;
        dir_reg[g]  <= 1'b0;
      end else if (clk_en_i) begin
        if (step_req[g] && pcnt_reg[g] == 16'h0000) begin
          pcnt_reg[g] <= 16'(PULSE_CYC);
          step_reg[g] <= 1'b1;
          dir_reg[g]  <= dir_wr[g];
        end else if (pcnt_reg[g] != 16'h0000) begin
          pcnt_reg[g] <= pcnt_reg[g] - 16'h0001;
          step_reg[g] <= (pcnt_reg[g] != 16'h0001);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power-on LED sequence
  // ----------------------------------------------------------------------
  sig_io_pkg::led_state_t st_reg;
  logic [31:0] tmr_reg;
  logic [2:0]  idx_reg;
  wire logic   tmr_done = (tmr_reg == 32'(BLINK_CYC - 1));
  assign state_reg = st_reg;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg  <= sig_io_pkg::ST_ALL_ON;
      tmr_reg <= 32'h0000_0000;
      idx_reg <= 3'h0;
    end else if (clk_en_i && st_reg != sig_io_pkg::ST_RUN) begin
      tmr_reg <= tmr_done ? 32'h0000_0000 : tmr_reg + 32'h0000_0001;
      if (tmr_done) begin
        unique case (st_reg)
          sig_io_pkg::ST_ALL_ON: st_reg <= sig_io_pkg::ST_ALL_OFF;
          sig_io_pkg::ST_ALL_OFF: st_reg <= sig_io_pkg::ST_WALK;
          sig_io_pkg::ST_WALK: begin
            st_reg <= sig_io_pkg::ST_ALL_OFF;
            if (idx_reg == 3'(sig_io_pkg::LED_CNT - 1)) begin
              st_reg <= sig_io_pkg::ST_RUN;
            end
            idx_reg <= idx_reg + 3'h1;
          end
          default: st_reg <= sig_io_pkg::ST_RUN;
        endcase
      end
    end
  end

  // LED order: 0..4 axis 1..5, 5 USB, 6 power.
  logic [6:0] led_mux;
  always_comb begin
    led_mux = 7'h00;
    unique case (st_reg)
      sig_io_pkg::ST_ALL_ON:  led_mux = 7'h7f;
      sig_io_pkg::ST_ALL_OFF: led_mux = 7'h00;
      sig_io_pkg::ST_WALK:    led_mux = 7'(7'h01 << idx_reg);
      default: led_mux = {1'b1, usb_sync, step_reg};
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      leds_o <= 7'h00;
    end else if (clk_en_i) begin
      leds_o <= led_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------------
  assign out_pins_o     = out_reg;
  assign motor_out_o    = out_reg[1:0];
  assign motor_in_o     = in_sync;
  assign drive_o.step   = step_reg;
  assign drive_o.dir    = dir_reg;
  assign drive_o.enable = motion_reg[sig_io_pkg::MOT_ENA_BIT];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  out_low_a: assert property (@(posedge ref_clk_i) $rose(reset_i) |=>
    out_pins_o == 8'h00) else $error("outputs not low after reset");
  mirror_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    motor_out_o == out_pins_o[1:0]) else $error("motor outputs differ");
  run_leds_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $past(st_reg) == sig_io_pkg::ST_RUN && $past(clk_en_i) |->
    leds_o[6] && leds_o[5] == $past(usb_sync))
    else $error("run LEDs wrong");
  pol_read_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    psel_i && !penable_i && !pwrite_i && hit_in && clk_en_i |=>
    prdata_o[7:0] == $past(in_sync ^ pol_reg)) else $error("input read");
  step_len_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(step_reg[0]) |-> step_reg[0] [*2]) else $error("step too short");
  c_run: cover property (@(posedge ref_clk_i) st_reg == sig_io_pkg::ST_RUN);
  c_step: cover property (@(posedge ref_clk_i) $rose(step_reg[0]));
  c_wr: cover property (@(posedge ref_clk_i) wr_en && hit_out);
  c_walk: cover property (@(posedge ref_clk_i) st_reg == sig_io_pkg::ST_WALK);
  c_usb_off: cover property (@(posedge ref_clk_i) !usb_sync && st_reg[3]);

  // ----------------------------------------------------------------------
  // Sequence, pin and drive checks
  // ----------------------------------------------------------------------
  // Each check except run_stay_a and out_hold_a waits for clk_en_i, since a frozen cycle keeps old values.

  all_on_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    st_reg == sig_io_pkg::ST_ALL_ON && clk_en_i |=> leds_o == 7'h7f)
    else $error("common blink not all on");

  walk_one_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    st_reg == sig_io_pkg::ST_WALK && clk_en_i |=>
    leds_o == 7'(7'h01 << $past(idx_reg)))
    else $error("walk step shows wrong LED");

  seq_end_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    st_reg == sig_io_pkg::ST_WALK && tmr_done && clk_en_i &&
    idx_reg == 3'(sig_io_pkg::LED_CNT - 1) |=> st_reg == sig_io_pkg::ST_RUN)
    else $error("sequence does not end after power LED");

  run_stay_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    st_reg == sig_io_pkg::ST_RUN |=> st_reg == sig_io_pkg::ST_RUN)
    else $error("left run state");

  usb_led_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    st_reg == sig_io_pkg::ST_RUN && clk_en_i && !usb_sync |=> !leds_o[5])
    else $error("USB LED lit without cable");

  axis_led_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    st_reg == sig_io_pkg::ST_RUN && clk_en_i |=> leds_o[4:0] == $past(step_reg))
    else $error("axis LEDs do not follow steps");

  step_end_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    pcnt_reg[0] == 16'h0001 && clk_en_i |=> !step_reg[0])
    else $error("step pulse does not end");

  pol_wr_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    wr_en && hit_pol |=> pol_reg == $past(pwdata_i[7:0]))
    else $error("polarity write lost");

  status_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    psel_i && !penable_i && !pwrite_i && hit_in && clk_en_i &&
    pol_reg == 8'h00 |=> prdata_o[7:0] == $past(in_sync))
    else $error("high line not reported open");

  out_hold_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    !(wr_en && hit_out) |=> $stable(out_pins_o))
    else $error("outputs changed without a write");

  out_wr_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    wr_en && hit_out |=> out_pins_o == $past(pwdata_i[7:0]))
    else $error("output write lost");

  dir_latch_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    clk_en_i && step_req[0] && pcnt_reg[0] == 16'h0000 |=>
    drive_o.dir[0] == $past(pwdata_i[8]))
    else $error("direction not latched with step");

  ena_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    wr_en && hit_mot |=>
    drive_o.enable == $past(pwdata_i[sig_io_pkg::MOT_ENA_BIT]))
    else $error("drive enable not stored");

  sync_lat_a: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    !$past(reset_i) && !$past(reset_i, 2) && $past(clk_en_i) &&
    $past(clk_en_i, 2) |-> motor_in_o == $past(in_pins_i, 2))
    else $error("input not two stages behind pin");

endmodule : sig_io_leds

// ---- verification/drive_box_model.sv ----
// Model of the drive box and host cable on the far side of the pins.
`timescale 1ns/1ns
module drive_box_model (
  // Clock.
  input  wire logic         ref_clk_i,
  // Stimulus from the bench.
  input  wire logic [7:0]   in_val_i,
  input  wire logic         cable_i,
  // Drive side.
  input  sig_io_pkg::drive_t drive_i,
  output logic      [7:0]   in_pins_o,
  output logic              usb_cable_o,
  output logic      [4:0]   step_seen_o = 5'h00
);
  // Switch lines change on the clock, unlike a real, unsynchronised contact.
  always @(posedge ref_clk_i) begin
    in_pins_o   <= in_val_i;
    usb_cable_o <= cable_i;
    step_seen_o <= step_seen_o | drive_i.step;
  end
endmodule : drive_box_model

// ---- verification/tb_cnc_signal_io_status_leds.sv ----
// Self-checking bench for the status LED and signal I/O block.
`timescale 1ns/1ns
module tb_cnc_signal_io_status_leds;
  logic ref_clk_i = 0, reset_i = 1, psel = 0, pen = 0, pwr = 0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd, v;
  logic prdy, perr, usb, err, cable = 1;
  logic [7:0] inp, outp, min, iv = 8'h00, pv;
  logic [1:0] mout;
  logic [4:0] seen, lseen = 5'h00, dv, edir = 5'h00;
  logic trk = 0;
  logic [6:0] leds, last = 7'h00;
  logic [6:0] seq[$];
  sig_io_pkg::drive_t drv;
  int n_fail = 0, checked = 0;

  sig_io_leds #(.BLINK_CYC(4), .PULSE_CYC(2)) dut (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .clk_en_i(1'b1), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .in_pins_i(inp),
    .usb_cable_i(usb), .out_pins_o(outp), .motor_out_o(mout),
    .motor_in_o(min), .drive_o(drv), .leds_o(leds));
  drive_box_model pm (.ref_clk_i(ref_clk_i), .in_val_i(iv),
    .cable_i(cable), .drive_i(drv), .in_pins_o(inp),
    .usb_cable_o(usb), .step_seen_o(seen));

  initial forever #10 ref_clk_i = ~ref_clk_i;
  always @(negedge ref_clk_i) if (trk) lseen <= lseen | leds[4:0];

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge ref_clk_i);
    pen <= 1;
    do begin
      @(posedge ref_clk_i);
    end while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 0;
    pen  <= 0;
    @(posedge ref_clk_i);
  endtask : apb

  function automatic logic [6:0] seq_exp(input int i);
    if (i == 0) return 7'h7f;
    if (i < 8) return 7'h01 << (i - 1);
    return 7'h60;
  endfunction : seq_exp

  task end_sim();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    repeat (4000) @(posedge ref_clk_i);
    n_fail++;
    end_sim();
  end

  initial begin
    void'($urandom(69459));
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 0;
    for (int i = 0; i < 600 && seq.size() < 9; i++) begin
      @(negedge ref_clk_i);
      if (leds !== 7'h00 && leds !== last) seq.push_back(leds);
      last = leds;
    end
    chk(seq.size(), 9);
    foreach (seq[i]) chk(seq[i], seq_exp(i));
    repeat (20) @(posedge ref_clk_i);
    chk(leds, 7'h60);
    cable <= 0;
    repeat (5) @(posedge ref_clk_i);
    chk(leds, 7'h40);
    cable <= 1;
    chk(outp, 8'h00);
    apb(0, sig_io_pkg::OUT_OFS, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'hff : (i == 1) ? 32'h0 : $urandom;
      apb(1, sig_io_pkg::OUT_OFS, v);
      chk(outp, v[7:0]);
      chk(mout, v[1:0]);
      iv <= (i == 0) ? 8'hff : $urandom;
      pv = $urandom;
      apb(1, sig_io_pkg::POL_OFS, {24'h0, pv});
      repeat (6) @(posedge ref_clk_i);
      chk(min, iv);
      apb(0, sig_io_pkg::IN_OFS, 32'h0);
      chk(rd[7:0], iv ^ pv);
    end
    apb(1, 12'h020, 32'h0);
    chk(err, 1'b1);
    chk(outp, v[7:0]);
    trk <= 1;
    for (int n = 0; n < 5; n++) begin
      dv = $urandom;
      edir[n] = dv[n];
      apb(1, sig_io_pkg::MOTION_OFS, {19'h0, dv, 8'h20 | (8'h01 << n)});
      repeat (20) @(posedge ref_clk_i);
      chk(drv.enable, 1'b1);
      chk(drv.dir, edir);
      chk(seen, (5'h02 << n) - 5'h01);
      chk(lseen, (5'h02 << n) - 5'h01);
    end
    end_sim();
  end
endmodule : tb_cnc_signal_io_status_leds
